// ### common/dnps_pkg.sv
package dnps_pkg;
  // ==========================================
  // port table geometry
  localparam int unsigned NUM_PORTS     = 160;
  localparam int unsigned LAST_PORT     = 160;
  localparam logic [7:0]  FINAL_PORT    = 8'h00A0;
  localparam logic [7:0]  FRAG_LIMIT    = 8'h0008;
  localparam logic [7:0]  WORD_BYTES    = 8'h0002;
  localparam logic [7:0]  PORT_BUF      = 8'h0008;
  // ==========================================
  // allocation caps
  localparam logic [7:0]  CAP_PEER_TX   = 8'h0010;
  localparam logic [7:0]  CAP_PEER_RX   = 8'h0090;
  localparam logic [7:0]  CAP_POLL      = 8'h003F;
  localparam logic [7:0]  CAP_STROBE_TX = 8'h0001;
  localparam logic [7:0]  CAP_STROBE_RX = 8'h003F;
  localparam logic [7:0]  CAP_TOTAL     = 8'h00A0;
  localparam logic [5:0]  MAX_NODE_ID   = 6'h3F;
  localparam logic [5:0]  MAX_SLAVE_PORTS = 6'h20;
  // ==========================================
  // slave status codes
  localparam logic [7:0]  ST_OK         = 8'h0000;
  localparam logic [7:0]  ST_PRODUCED   = 8'h0031;
  localparam logic [7:0]  ST_CONSUMED   = 8'h0032;
  localparam logic [7:0]  ST_STATION    = 8'h002F;
  // ==========================================
  // timing
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned RX_TIMEOUT_US = 100;
  localparam int unsigned RX_TIMEOUT_CYC = RX_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    DNPS_CT_NONE      = 3'b000,
    DNPS_CT_PEER_TX   = 3'b001,
    DNPS_CT_PEER_RX   = 3'b010,
    DNPS_CT_POLL      = 3'b011,
    DNPS_CT_STROBE_TX = 3'b100,
    DNPS_CT_STROBE_RX = 3'b101
  } dnps_ctype_t;

  typedef enum logic [1:0] {
    DNPS_MODE_OFF    = 2'b00,
    DNPS_MODE_MASTER = 2'b01,
    DNPS_MODE_SLAVE  = 2'b10,
    DNPS_MODE_PEER   = 2'b11
  } dnps_mode_t;
endpackage : dnps_pkg

// ### common/dnps_cfg_if.sv
`timescale 1ns/10ps
interface dnps_cfg_if;
  logic                     wrEn;
  logic [7:0]               wrPort;
  logic [2:0]               wrType;
  logic [7:0]               wrInBytes;
  logic [7:0]               wrOutBytes;
  logic [7:0]               rdPort;
  logic [2:0]               rdType;
  logic [7:0]               rdInBytes;
  logic [7:0]               rdOutBytes;
  modport table_side (input wrEn, wrPort, wrType, wrInBytes, wrOutBytes, rdPort,
                      output rdType, rdInBytes, rdOutBytes);
  modport user_side  (output wrEn, wrPort, wrType, wrInBytes, wrOutBytes, rdPort,
                      input rdType, rdInBytes, rdOutBytes);
endinterface : dnps_cfg_if

// ### src/dnps_port_table.sv
`timescale 1ns/10ps
// ==========================================
// port table memory, registered read
module dnps_port_table #(
  parameter int unsigned DEPTH = 161
) (
  input wire logic clk,
  dnps_cfg_if.table_side cfg
);
  typedef struct packed {
    logic [2:0] ctype;
    logic [7:0] inBytes;
    logic [7:0] outBytes;
  } dnps_entry_t;

  dnps_entry_t mem [DEPTH];
  dnps_entry_t rdEntry;

  always_ff @(posedge clk) begin
    if (cfg.wrEn) begin
      mem[cfg.wrPort] <= '{cfg.wrType, cfg.wrInBytes, cfg.wrOutBytes};
    end
    rdEntry <= mem[cfg.rdPort];
  end

  assign cfg.rdType     = rdEntry.ctype;
  assign cfg.rdInBytes  = rdEntry.inBytes;
  assign cfg.rdOutBytes = rdEntry.outBytes;
endmodule : dnps_port_table

// ### src/dnps_bit_reverse.sv
`timescale 1ns/10ps
// ==========================================
// 16-bit word bit reversal with bypass
module dnps_bit_reverse #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             enable,
  input  wire logic             bypass,
  input  wire logic [WIDTH-1:0] dataIn,
  output logic      [WIDTH-1:0] dataOut
);
  logic [WIDTH-1:0] reversed;

  for (genvar i = 0; i < WIDTH; i++) begin : g_rev
    assign reversed[i] = dataIn[WIDTH-1-i];
  end

  assign dataOut = (enable && !bypass) ? reversed : dataIn;
endmodule : dnps_bit_reverse

// ### src/dnps_port_setup.sv
`timescale 1ns/10ps
// How it works
// [RL1] byte count above 8 marks that direction fragmented
// [RL2] master mode compares slave sizes before connecting, refuses on form mismatch
// [RL3] refused poll: 0x31 produced-size mismatch, 0x32 consumed-size mismatch
// [RL4] master also refuses when transmit size exceeds receive size
// [RL5] peer mode skips every size check
// [RL6] slave mode skips every size check
// [RL7] per-type caps 16, 144, 63, 1, 63 ports
// [RL8] total allocated ports at most 160, fragmented counts once
// [RL9] byte count of one still uses a whole word
// [RL10] one to 32 ports per slave, node ids 0 to 0x3F
// [RL11] final port 0xA0 holds at most 8 bytes
// [RL12] extended buffers of large ports may not overlap
// [RL13] format-conversion areas are never bit-reversed
// [RL14] station status on non-station destination refuses with 0x2F
// [RL15] station status taken once at connection
// [RL16] strobe exchange only with a strobe transmit port present
// [RL17] disabled communication kind stops all traffic
// [RL18] one communication type per port
// [RL19] configuring party gives both counts, unused set to 0
// [RL20] configuring party avoids bit reversal on numeric slaves
// [RL21] timeout flag when no reply after successful transmit
// [RL22] bit reversal swaps bit order in each 16-bit word
module dnps_port_setup #(
  parameter int unsigned TIMEOUT_CYC = dnps_pkg::RX_TIMEOUT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  commMode,
  input  wire logic        cfgWrEn,
  input  wire logic [7:0]  cfgPort,
  input  wire logic [2:0]  cfgType,
  input  wire logic [7:0]  cfgInBytes,
  input  wire logic [7:0]  cfgOutBytes,
  input  wire logic        connReq,
  input  wire logic [5:0]  connNode,
  input  wire logic [5:0]  connPortCount,
  input  wire logic [7:0]  slaveProduced,
  input  wire logic [7:0]  slaveConsumed,
  input  wire logic [7:0]  myTxBytes,
  input  wire logic [7:0]  myRxBytes,
  input  wire logic        wantStationStatus,
  input  wire logic        destIsStation,
  input  wire logic [7:0]  stationStatusIn,
  input  wire logic        txDone,
  input  wire logic        rxSeen,
  input  wire logic        bitRevEn,
  input  wire logic        inConvArea,
  input  wire logic [15:0] wordIn,
  output logic             cfgAccept,
  output logic             cfgReject,
  output logic             connDone,
  output logic             connOk,
  output logic [7:0]       slaveStatus,
  output logic [7:0]       stationStatus,
  output logic             strobeActive,
  output logic             commEnabled,
  output logic             fragTx,
  output logic             fragRx,
  output logic [7:0]       inWords,
  output logic             slaveTimeout,
  output logic [15:0]      wordOut
);
  // ==========================================
  // state
  localparam int unsigned LAST_W = 8;

  typedef enum logic [1:0] {
    DNPS_ST_IDLE  = 2'b00,
    DNPS_ST_CHECK = 2'b01,
    DNPS_ST_WAIT  = 2'b10
  } dnps_state_t;

  typedef struct packed {
    dnps_state_t state;
    logic [7:0]  cntPeerTx;
    logic [7:0]  cntPeerRx;
    logic [7:0]  cntPoll;
    logic [7:0]  cntStrobeTx;
    logic [7:0]  cntStrobeRx;
    logic [7:0]  cntTotal;
    logic [LAST_W-1:0] reach;
    logic        cfgAccept;
    logic        cfgReject;
    logic        connDone;
    logic        connOk;
    logic [7:0]  slaveStatus;
    logic [7:0]  stationStatus;
    logic        fragTx;
    logic        fragRx;
    logic [7:0]  inWords;
    logic        monitoring;
    logic [31:0] toCnt;
    logic        slaveTimeout;
    logic [15:0] wordOut;
    logic        commEnabled;
    logic        strobeActive;
  } dnps_regs_t;

  dnps_regs_t       r;
  dnps_regs_t       next_r;
  logic [15:0]      revWord;
  logic [7:0]       extEnd;
  logic [7:0]       maxBytes;
  logic             typeFull;
  logic             overlap;
  logic             badPort;
  logic             cfgBad;

  // accepted entries land in the port table
  dnps_cfg_if cfgBus ();

  assign cfgBus.wrEn       = cfgWrEn && !cfgBad; // RL18
  assign cfgBus.wrPort     = cfgPort;
  assign cfgBus.wrType     = cfgType;
  assign cfgBus.wrInBytes  = cfgInBytes;
  assign cfgBus.wrOutBytes = cfgOutBytes;
  assign cfgBus.rdPort     = cfgPort;

  dnps_port_table #(.DEPTH(dnps_pkg::NUM_PORTS + 1)) u_table (
    .clk (clk),
    .cfg (cfgBus.table_side)
  );

  dnps_bit_reverse #(.WIDTH(16)) u_rev (
    .enable  (bitRevEn),
    .bypass  (inConvArea), // RL13
    .dataIn  (wordIn),
    .dataOut (revWord)      // RL22
  );

  // ==========================================
  // configuration check
  always_comb begin
    maxBytes = (cfgInBytes > cfgOutBytes) ? cfgInBytes : cfgOutBytes;
    // extended buffer reaches into following ports
    extEnd   = cfgPort + 8'((maxBytes + dnps_pkg::PORT_BUF - 8'h01) / dnps_pkg::PORT_BUF) - 8'h01; // RL12
    unique case (dnps_pkg::dnps_ctype_t'(cfgType))
      dnps_pkg::DNPS_CT_PEER_TX:   typeFull = r.cntPeerTx   >= dnps_pkg::CAP_PEER_TX;   // RL7
      dnps_pkg::DNPS_CT_PEER_RX:   typeFull = r.cntPeerRx   >= dnps_pkg::CAP_PEER_RX;   // RL7
      dnps_pkg::DNPS_CT_POLL:      typeFull = r.cntPoll     >= dnps_pkg::CAP_POLL;      // RL7
      dnps_pkg::DNPS_CT_STROBE_TX: typeFull = r.cntStrobeTx >= dnps_pkg::CAP_STROBE_TX; // RL7
      dnps_pkg::DNPS_CT_STROBE_RX: typeFull = r.cntStrobeRx >= dnps_pkg::CAP_STROBE_RX; // RL7
      default:                     typeFull = 1'b1;
    endcase
    // ports must be allocated in ascending order; overlap with previous reach
    overlap = (r.reach != 8'h00) && (cfgPort < r.reach); // RL12 RL18
    badPort = (cfgPort == 8'h00) || (cfgPort > dnps_pkg::FINAL_PORT)
           || (extEnd > dnps_pkg::FINAL_PORT)                                   // RL12
           || ((cfgPort == dnps_pkg::FINAL_PORT) && (maxBytes > dnps_pkg::FRAG_LIMIT)); // RL11
    cfgBad  = typeFull || overlap || badPort || (r.cntTotal >= dnps_pkg::CAP_TOTAL); // RL8
  end

  // ==========================================
  // next state
  always_comb begin
    next_r = r;
    next_r.cfgAccept = 1'b0;
    next_r.cfgReject = 1'b0;
    next_r.connDone  = 1'b0;
    next_r.commEnabled = (commMode != dnps_pkg::DNPS_MODE_OFF); // RL17
    next_r.strobeActive = next_r.commEnabled && (r.cntStrobeTx != 8'h00); // RL16
    next_r.wordOut = revWord;

    if (cfgWrEn) begin
      if (cfgBad) begin // RL8
        next_r.cfgReject = 1'b1;
      end else begin
        next_r.cfgAccept = 1'b1;
        next_r.cntTotal  = r.cntTotal + 8'h01; // RL8
        next_r.reach     = extEnd + 8'h01;
        next_r.fragTx    = cfgOutBytes > dnps_pkg::FRAG_LIMIT; // RL1
        next_r.fragRx    = cfgInBytes  > dnps_pkg::FRAG_LIMIT; // RL1
        next_r.inWords   = (cfgInBytes + 8'h01) >> 1;          // RL9
        unique case (dnps_pkg::dnps_ctype_t'(cfgType))
          dnps_pkg::DNPS_CT_PEER_TX:   next_r.cntPeerTx   = r.cntPeerTx + 8'h01;
          dnps_pkg::DNPS_CT_PEER_RX:   next_r.cntPeerRx   = r.cntPeerRx + 8'h01;
          dnps_pkg::DNPS_CT_POLL:      next_r.cntPoll     = r.cntPoll + 8'h01;
          dnps_pkg::DNPS_CT_STROBE_TX: next_r.cntStrobeTx = r.cntStrobeTx + 8'h01;
          default:                     next_r.cntStrobeRx = r.cntStrobeRx + 8'h01;
        endcase
      end
    end

    if (r.state == DNPS_ST_IDLE) begin
      if (connReq && next_r.commEnabled) begin
        next_r.state = DNPS_ST_CHECK;
      end
    end else if (r.state == DNPS_ST_CHECK) begin
      next_r.state    = DNPS_ST_IDLE;
      next_r.connDone = 1'b1;
      next_r.connOk   = 1'b1;
      next_r.slaveStatus = dnps_pkg::ST_OK;
      if ((connPortCount == 6'h00) || (connPortCount > dnps_pkg::MAX_SLAVE_PORTS)
          || (connNode > dnps_pkg::MAX_NODE_ID)) begin // RL10
        next_r.connOk = 1'b0;
      end
      if (commMode == dnps_pkg::DNPS_MODE_MASTER) begin // RL2 RL5 RL6
        if (((slaveProduced > dnps_pkg::FRAG_LIMIT) != (myRxBytes > dnps_pkg::FRAG_LIMIT))
            || (slaveProduced != myRxBytes)) begin // RL2
          next_r.connOk      = 1'b0;
          next_r.slaveStatus = dnps_pkg::ST_PRODUCED; // RL3
        end else if (((slaveConsumed > dnps_pkg::FRAG_LIMIT) != (myTxBytes > dnps_pkg::FRAG_LIMIT))
                     || (slaveConsumed != myTxBytes)) begin
          next_r.connOk      = 1'b0;
          next_r.slaveStatus = dnps_pkg::ST_CONSUMED; // RL3
        end else if (myTxBytes > myRxBytes) begin
          next_r.connOk      = 1'b0;
          next_r.slaveStatus = dnps_pkg::ST_CONSUMED; // RL4
        end
      end
      if (wantStationStatus && !destIsStation) begin
        next_r.connOk      = 1'b0;
        next_r.slaveStatus = dnps_pkg::ST_STATION; // RL14
      end else if (wantStationStatus && next_r.connOk) begin
        next_r.stationStatus = stationStatusIn; // RL15
      end
      next_r.monitoring = 1'b0;
      next_r.toCnt      = 32'h0000_0000;
    end

    // reply monitoring armed by a good transmit
    if (txDone && r.connOk && next_r.commEnabled) begin
      next_r.monitoring = 1'b1; // RL21
      next_r.toCnt      = 32'h0000_0000;
    end else if (r.monitoring) begin
      if (rxSeen) begin
        next_r.monitoring   = 1'b0;
        next_r.slaveTimeout = 1'b0;
      end else if (r.toCnt >= 32'(TIMEOUT_CYC - 1)) begin
        next_r.monitoring   = 1'b0;
        next_r.slaveTimeout = 1'b1; // RL21
      end else begin
        next_r.toCnt = r.toCnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cfgAccept     = r.cfgAccept;
  assign cfgReject     = r.cfgReject;
  assign connDone      = r.connDone;
  assign connOk        = r.connOk;
  assign slaveStatus   = r.slaveStatus;
  assign stationStatus = r.stationStatus;
  assign strobeActive  = r.strobeActive;
  assign commEnabled   = r.commEnabled;
  assign fragTx        = r.fragTx;
  assign fragRx        = r.fragRx;
  assign inWords       = r.inWords;
  assign slaveTimeout  = r.slaveTimeout;
  assign wordOut       = r.wordOut;

  // ==========================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  cap_strobe_tx_a: assert property (r.cntStrobeTx <= dnps_pkg::CAP_STROBE_TX) // RL7
    else $error("strobe transmit cap exceeded");
  total_cap_a: assert property (r.cntTotal <= dnps_pkg::CAP_TOTAL) // RL8
    else $error("total port cap exceeded");
  frag_flag_a: assert property (cfgWrEn && !typeFull && !overlap && !badPort
      && r.cntTotal < dnps_pkg::CAP_TOTAL && cfgOutBytes > dnps_pkg::FRAG_LIMIT |=> fragTx) // RL1
    else $error("fragmented transmit not flagged");
  final_port_a: assert property (cfgWrEn && cfgPort == dnps_pkg::FINAL_PORT
      && cfgInBytes > dnps_pkg::FRAG_LIMIT |=> cfgReject) // RL11
    else $error("final port accepted large count");
  station_refuse_a: assert property (r.state == DNPS_ST_CHECK && wantStationStatus && !destIsStation
      |=> connDone && !connOk && slaveStatus == dnps_pkg::ST_STATION) // RL14
    else $error("station status refusal missing");
  tx_gt_rx_a: assert property (r.state == DNPS_ST_CHECK && commMode == dnps_pkg::DNPS_MODE_MASTER
      && myTxBytes > myRxBytes |=> !connOk) // RL4
    else $error("oversized transmit accepted");
  peer_nocheck_a: assert property (r.state == DNPS_ST_CHECK && commMode == dnps_pkg::DNPS_MODE_PEER
      && !wantStationStatus && connPortCount == 6'h01 && connNode <= dnps_pkg::MAX_NODE_ID
      |=> connOk) // RL5
    else $error("peer mode size checked");
  comm_off_a: assert property (commMode == dnps_pkg::DNPS_MODE_OFF |=> !commEnabled && !strobeActive) // RL17
    else $error("communication not disabled");
  rev_word_a: assert property (bitRevEn && !inConvArea |=> wordOut == 16'({<<{$past(wordIn)}})) // RL22
    else $error("word not reversed");
  conv_bypass_a: assert property (inConvArea |=> wordOut == $past(wordIn)) // RL13
    else $error("conversion area reversed");

  cov_frag_c:   cover property (cfgAccept && fragTx);
  cov_refuse_c: cover property (connDone && slaveStatus == dnps_pkg::ST_PRODUCED);
  cov_ok_c:     cover property (connDone && connOk);
  cov_to_c:     cover property ($rose(slaveTimeout));
endmodule : dnps_port_setup

// ### testbench/dnps_slave_model.sv
`timescale 1ns/10ps
// ==========================================
// far-side slave: reports a finished transmit, then replies unless silent
module dnps_slave_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic kick,
  input  wire logic silent,
  output logic      txDone,
  output logic      rxSeen
);
  logic [1:0] pend;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txDone <= 1'b0;
      rxSeen <= 1'b0;
      pend   <= 2'b00;
    end else begin
      txDone <= kick;
      pend   <= {pend[0], txDone};
      rxSeen <= pend[1] & ~silent;
    end
  end
endmodule : dnps_slave_model

// ### testbench/dnps_port_setup_bench.sv
`timescale 1ns/10ps
module dnps_port_setup_bench;
  localparam logic [2:0] POLL = dnps_pkg::DNPS_CT_POLL;
  localparam logic [2:0] PTX  = dnps_pkg::DNPS_CT_PEER_TX;
  localparam logic [2:0] PRX  = dnps_pkg::DNPS_CT_PEER_RX;
  localparam logic [2:0] STX  = dnps_pkg::DNPS_CT_STROBE_TX;
  localparam logic [2:0] SRX  = dnps_pkg::DNPS_CT_STROBE_RX;
  logic        clk, rst_n, cfgWrEn, connReq, wantStationStatus, destIsStation;
  logic        txDone, rxSeen, bitRevEn, inConvArea, kick, silent;
  logic        cfgAccept, cfgReject, connDone, connOk, strobeActive, commEnabled;
  logic        fragTx, fragRx, slaveTimeout;
  logic [1:0]  commMode;
  logic [2:0]  cfgType;
  logic [5:0]  connNode, connPortCount;
  logic [7:0]  cfgPort, cfgInBytes, cfgOutBytes, slaveProduced, slaveConsumed;
  logic [7:0]  myTxBytes, myRxBytes, stationStatusIn, slaveStatus, stationStatus, inWords, expSt;
  logic [15:0] wordIn, wordOut, expWord;
  logic [10:0] cfgQ[$];
  logic [8:0]  connQ[$];
  logic [10:0] cfgNote;
  logic [8:0]  connNote;
  int          errCount, checksDone, cycles, seedDummy;

  dnps_slave_model dnps_slave_model_i (.clk, .rst_n, .kick, .silent, .txDone, .rxSeen);

  dnps_port_setup #(.TIMEOUT_CYC(8)) dnps_port_setup_i (
    .clk, .rst_n, .commMode, .cfgWrEn, .cfgPort, .cfgType, .cfgInBytes, .cfgOutBytes,
    .connReq, .connNode, .connPortCount, .slaveProduced, .slaveConsumed, .myTxBytes,
    .myRxBytes, .wantStationStatus, .destIsStation, .stationStatusIn, .txDone, .rxSeen,
    .bitRevEn, .inConvArea, .wordIn, .cfgAccept, .cfgReject, .connDone, .connOk,
    .slaveStatus, .stationStatus, .strobeActive, .commEnabled, .fragTx, .fragRx,
    .inWords, .slaveTimeout, .wordOut);

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ==========================================
  // drivers; cfg and conn note their expected results, txPulse notes none
  task automatic cfg(input logic [7:0] port, input logic [2:0] ty, input logic [7:0] inB,
                     input logic [7:0] outB, input logic acc);
    cfgWrEn = 1'b1;
    cfgPort = port;
    cfgType = ty;
    cfgInBytes = inB;
    cfgOutBytes = outB;
    cfgQ.push_back({acc, outB > 8'h08, inB > 8'h08, (inB + 8'h01) >> 1});
    @(negedge clk);
  endtask : cfg

  task automatic conn(input logic [7:0] prod, input logic [7:0] cons, input logic [7:0] tx,
                      input logic [7:0] rx, input logic want, input logic isSt, input logic [8:0] exp);
    slaveProduced = prod;
    slaveConsumed = cons;
    myTxBytes = tx;
    myRxBytes = rx;
    wantStationStatus = want;
    destIsStation = isSt;
    connNode = 6'($urandom_range(63, 0));
    connPortCount = 6'($urandom_range(32, 1));
    connReq = 1'b1;
    if (commMode != dnps_pkg::DNPS_MODE_OFF) connQ.push_back(exp);
    @(negedge clk);
    connReq = 1'b0;
    repeat (4) @(negedge clk);
  endtask : conn

  task automatic txPulse(input logic quiet);
    silent = quiet;
    kick = 1'b1;
    @(negedge clk);
    kick = 1'b0;
  endtask : txPulse

  // ==========================================
  // monitor: oldest note against each result pulse
  always @(negedge clk) begin
    if (rst_n && (cfgAccept || cfgReject)) begin
      if (cfgQ.size() == 0) chk("cfg unexpected", 16'h0000, 16'h0001);
      else begin
        cfgNote = cfgQ.pop_front();
        chk("cfg accept", {15'h0000, cfgNote[10]}, {15'h0000, cfgAccept});
        if (cfgNote[10]) chk("cfg frag words", {6'h00, cfgNote[9:0]}, {6'h00, fragTx, fragRx, inWords});
      end
    end
    if (rst_n && connDone) begin
      if (connQ.size() == 0) chk("conn unexpected", 16'h0000, 16'h0001);
      else begin
        connNote = connQ.pop_front();
        chk("conn result", {7'h00, connNote}, {7'h00, connOk, slaveStatus});
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      $display("Error run length expected below 5000 cycles seen %0d", cycles);
      end_sim();
    end
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================
  // main sequence
  initial begin
    seedDummy = $urandom(76);
    {rst_n, cfgWrEn, connReq, wantStationStatus, destIsStation, bitRevEn, inConvArea, kick, silent} = '0;
    {commMode, cfgType, connNode, connPortCount, cfgPort, cfgInBytes, cfgOutBytes} = '0;
    {slaveProduced, slaveConsumed, myTxBytes, myRxBytes, stationStatusIn, wordIn} = '0;
    repeat (8) @(negedge clk);
    chk("reset outputs", 16'h0000, {5'h00, connOk, strobeActive, slaveTimeout, slaveStatus});
    rst_n = 1'b1;
    commMode = dnps_pkg::DNPS_MODE_MASTER;
    repeat (20) @(negedge clk);
    chk("timeout before transmit", 16'h0000, {15'h0000, slaveTimeout});
    chk("comm enabled", 16'h0001, {15'h0000, commEnabled});
    cfg(8'h00, POLL, 8'h02, 8'h02, 1'b0);
    cfg(8'h01, POLL, 8'h01, 8'h01, 1'b1);
    cfg(8'h02, POLL, 8'h09, 8'h09, 1'b1);
    cfg(8'h03, POLL, 8'h02, 8'h02, 1'b0);
    for (int p = 4; p < 21; p++) cfg(p[7:0], PTX, 8'h00, 8'($urandom_range(8, 1)), p < 20);
    cfg(8'h15, SRX, 8'h02, 8'h00, 1'b1);
    cfgWrEn = 1'b0;
    repeat (3) @(negedge clk);
    chk("strobe with receive only", 16'h0000, {15'h0000, strobeActive});
    cfg(8'h16, STX, 8'h00, 8'h02, 1'b1);
    cfg(8'h17, STX, 8'h00, 8'h02, 1'b0);
    cfg(8'hA0, PRX, 8'h09, 8'h00, 1'b0);
    cfg(8'hA1, PRX, 8'h02, 8'h00, 1'b0);
    cfg(8'hA0, PRX, 8'h08, 8'h00, 1'b1);
    cfgWrEn = 1'b0;
    repeat (3) @(negedge clk);
    chk("strobe with transmit port", 16'h0001, {15'h0000, strobeActive});
    conn(8'h04, 8'h04, 8'h04, 8'h04, 1'b0, 1'b0, {1'b1, dnps_pkg::ST_OK});
    conn(8'h04, 8'h0C, 8'h0C, 8'h0C, 1'b0, 1'b0, {1'b0, dnps_pkg::ST_PRODUCED});
    conn(8'h0C, 8'h04, 8'h0C, 8'h0C, 1'b0, 1'b0, {1'b0, dnps_pkg::ST_CONSUMED});
    conn(8'h04, 8'h06, 8'h06, 8'h04, 1'b0, 1'b0, {1'b0, dnps_pkg::ST_CONSUMED});
    conn(8'h04, 8'h04, 8'h04, 8'h04, 1'b1, 1'b0, {1'b0, dnps_pkg::ST_STATION});
    expSt = 8'($urandom_range(255, 1));
    stationStatusIn = expSt;
    conn(8'h04, 8'h04, 8'h04, 8'h04, 1'b1, 1'b1, {1'b1, dnps_pkg::ST_OK});
    chk("station status", {8'h00, expSt}, {8'h00, stationStatus});
    stationStatusIn = ~expSt;
    repeat (4) @(negedge clk);
    chk("station status held", {8'h00, expSt}, {8'h00, stationStatus});
    connPortCount = 6'h21;
    connReq = 1'b1;
    connQ.push_back({1'b0, dnps_pkg::ST_OK});
    @(negedge clk);
    connReq = 1'b0;
    repeat (4) @(negedge clk);
    chk("slave port range", 16'h0000, {15'h0000, connOk});
    for (int m = 2; m < 4; m++) begin
      commMode = m[1:0];
      @(negedge clk);
      conn(8'h04, 8'h0C, 8'h06, 8'h02, 1'b0, 1'b0, {1'b1, dnps_pkg::ST_OK});
    end
    commMode = dnps_pkg::DNPS_MODE_OFF;
    repeat (2) @(negedge clk);
    chk("comm disabled", 16'h0000, {15'h0000, commEnabled});
    conn(8'h04, 8'h04, 8'h04, 8'h04, 1'b0, 1'b0, 9'h000);
    commMode = dnps_pkg::DNPS_MODE_MASTER;
    for (int i = 0; i < 12; i++) begin
      wordIn = 16'($urandom());
      bitRevEn = i[0];
      inConvArea = i[1];
      for (int b = 0; b < 16; b++) expWord[b] = (bitRevEn && !inConvArea) ? wordIn[15-b] : wordIn[b];
      @(negedge clk);
      chk("word out", expWord, wordOut);
    end
    txPulse(1'b0);
    repeat (14) @(negedge clk);
    chk("timeout with reply", 16'h0000, {15'h0000, slaveTimeout});
    txPulse(1'b1);
    repeat (3) @(negedge clk);
    chk("timeout too early", 16'h0000, {15'h0000, slaveTimeout});
    repeat (12) @(negedge clk);
    chk("timeout silent slave", 16'h0001, {15'h0000, slaveTimeout});
    repeat (4) @(negedge clk);
    chk("pending notes", 16'h0000, 16'(cfgQ.size() + connQ.size()));
    end_sim();
  end
endmodule : dnps_port_setup_bench
